// file: sync_burst_sram_map.vh
// Purpose: shared constants of the burst sram control decode
// Assumes: included by its bare name from every design file
// Notes:   widths are defaults only; the control module takes only the address width and HAS_CE3 as parameters
//
// Behaviour
// RULE1 - capture address on strobe with all enables active
// RULE2 - low two address bits seed burst counter
// RULE3 - byte select writes lane only with qualifier
// RULE4 - global write low writes every byte lane
// RULE5 - advance low steps burst counter each edge
// RULE6 - second chip enable active high, combined
// RULE7 - first chip enable active low, sampled
// RULE8 - optional third chip enable active low
// RULE9 - processor strobe ignored when first enable high
// RULE10 - processor strobe loads address and counter
// RULE11 - processor strobe wins when both strobes low
// RULE12 - output enable low drives, high floats data
// RULE13 - output enable masked first read after deselect
// RULE14 - controller strobe loads address and counter
// RULE15 - master drives qualifier low for byte writes
// RULE16 - float outputs on write, deselect, after deselect
// RULE17 - sleep input high idles, keeps stored data
// RULE18 - four-beat linear or interleaved burst order
`ifndef SYNC_BURST_SRAM_MAP_VH
`define SYNC_BURST_SRAM_MAP_VH
`define SBS_ADDR_W      18
`define SBS_BURST_W     2
`define SBS_LANES       4
`define SBS_BYTE_W      8
`define SBS_LANE_W      9
`define SBS_LANE_ALL    4'hf
`define SBS_LANE_NONE   4'h0
`define SBS_BURST_ZERO  2'h0
`define SBS_BURST_ONE   2'h1
`define SBS_HAS_CE3     1
`endif

// file: burst_seq_counter.v
// Purpose: two-bit burst counter with linear or interleaved order
// Assumes: load and advance come from the same clock domain
// Notes:   offset_d_o is the offset used by the access at this edge
`timescale 1ns/1ps
`include "sync_burst_sram_map.vh"
module burst_seq_counter #(
  parameter BW = `SBS_BURST_W
) (
  input  wire          sys_clk_i,
  input  wire          rst_n_i,
  input  wire          load_i,
  input  wire [BW-1:0] load_val_i,
  input  wire          advance_i,
  input  wire          interleave_i,
  output wire [BW-1:0] offset_d_o,
  output wire [BW-1:0] offset_q_o
);
  reg [BW-1:0] start_q;
  reg [BW-1:0] start_d;
  reg [BW-1:0] cnt_q;
  reg [BW-1:0] cnt_d;

  // xor order for interleaved, wrapping sum for linear
  function [BW-1:0] seq_offset;
    input [BW-1:0] start;
    input [BW-1:0] cnt;
    input          ilv;
    begin
      if (ilv)
        seq_offset = start ^ cnt;
      else
        seq_offset = start + cnt;
    end
  endfunction

  always @*
  begin
    start_d = start_q;
    cnt_d   = cnt_q;
    if (load_i)
    begin
      start_d = load_val_i; // see RULE2
      cnt_d   = {BW{1'b0}};
    end
    else if (advance_i)
      cnt_d = cnt_q + {{(BW-1){1'b0}}, 1'b1}; // see RULE5
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      start_q <= {BW{1'b0}};
      cnt_q   <= {BW{1'b0}};
    end
    else
    begin
      start_q <= start_d;
      cnt_q   <= cnt_d;
    end
  end

  assign offset_d_o = seq_offset(start_d, cnt_d, interleave_i); // see RULE18
  assign offset_q_o = seq_offset(start_q, cnt_q, interleave_i);
endmodule // burst_seq_counter

// file: sram_word_store.v
// Purpose: storage array with per-lane write and registered read
// Assumes: one access per clock; read returns the old word on write
// Notes:   no reset on the array, contents are undefined at power up
`timescale 1ns/1ps
`include "sync_burst_sram_map.vh"
module sram_word_store #(
  parameter AW    = `SBS_ADDR_W,
  parameter LANES = `SBS_LANES,
  parameter LW    = `SBS_LANE_W
) (
  input  wire                sys_clk_i,
  input  wire [AW-1:0]       addr_i,
  input  wire [LANES-1:0]    lane_wr_i,
  input  wire [LANES*LW-1:0] wdata_i,
  output reg  [LANES*LW-1:0] rdata_q
);
  reg [LANES*LW-1:0] mem [0:(1<<AW)-1];
  integer l;

  always @(posedge sys_clk_i)
  begin
    for (l = 0; l < LANES; l = l + 1)
      if (lane_wr_i[l])
        mem[addr_i][l*LW +: LW] <= wdata_i[l*LW +: LW];
    rdata_q <= mem[addr_i];
  end
endmodule // sram_word_store

// file: sync_burst_sram_control_inputs.v
// Purpose: synchronous control decode of a flow-through burst sram
// Assumes: bus inputs are synchronous to sys_clk_i; oe, sleep and
//          burst order are asynchronous and are synchronised here
// Notes:   data pins are split into in, out and output enable
`timescale 1ns/1ps
`include "sync_burst_sram_map.vh"
module sync_burst_sram_control_inputs #(
  parameter AW      = `SBS_ADDR_W,
  parameter HAS_CE3 = `SBS_HAS_CE3
) (
  input  wire                  sys_clk_i,
  input  wire                  rst_n_i,
  input  wire [AW-1:2]         addr_upper_i,
  input  wire                  addr_bit_one_i,
  input  wire                  addr_bit_zero_i,
  input  wire                  proc_addr_strobe_n_i,
  input  wire                  ctrl_addr_strobe_n_i,
  input  wire                  burst_advance_n_i,
  input  wire                  byte_lane0_write_sel_n_i,
  input  wire                  byte_lane1_write_sel_n_i,
  input  wire                  byte_lane2_write_sel_n_i,
  input  wire                  byte_lane3_write_sel_n_i,
  input  wire                  byte_write_qualifier_n_i,
  input  wire                  all_bytes_write_n_i,
  input  wire                  chip_sel_primary_n_i,
  input  wire                  chip_sel_expand_hi_i,
  input  wire                  chip_sel_expand_lo_n_i,
  input  wire                  output_enable_n_i,
  input  wire                  sleep_request_i,
  input  wire                  burst_order_interleaved_i,
  input  wire [31:0]           dq_i,
  input  wire [3:0]            io_parity_lines_i,
  output wire [31:0]           dq_o,
  output wire [3:0]            io_parity_lines_o,
  output reg                   dq_oe_o,
  output reg                   selected_o,
  output reg                   sleep_active_o
);
  localparam LANES = `SBS_LANES;
  localparam BYW   = `SBS_BYTE_W;
  localparam LW    = `SBS_LANE_W;
  localparam BW    = `SBS_BURST_W;

  // two-flop synchronisers for the asynchronous pins
  reg oe_n_meta_q;
  reg oe_n_sync_q;
  reg sleep_meta_q;
  reg sleep_sync_q;
  reg ilv_meta_q;
  reg ilv_sync_q;

  reg           selected_q;
  reg [AW-1:2]  base_q;
  reg [AW-1:2]  base_d;
  reg           sel_d;
  reg           proc_load;
  reg           ctrl_load;
  reg           strobe_load;
  reg           chip_active;
  reg           access;
  reg           is_write;
  reg [LANES-1:0] lane_wr;
  reg [LANES-1:0] lane_sel;
  reg           oe_d;
  reg [LANES*LW-1:0] wdata;
  wire [LANES*LW-1:0] rdata;
  wire [BW-1:0] offset_d;
  wire          ce3_active;
  integer       i;

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      oe_n_meta_q  <= 1'b1;
      oe_n_sync_q  <= 1'b1;
      sleep_meta_q <= 1'b0;
      sleep_sync_q <= 1'b0;
      ilv_meta_q   <= 1'b0;
      ilv_sync_q   <= 1'b0;
    end
    else
    begin
      oe_n_meta_q  <= output_enable_n_i;
      oe_n_sync_q  <= oe_n_meta_q;
      sleep_meta_q <= sleep_request_i;
      sleep_sync_q <= sleep_meta_q;
      ilv_meta_q   <= burst_order_interleaved_i;
      ilv_sync_q   <= ilv_meta_q;
    end
  end

  // variants without the third enable see it as always active
  assign ce3_active = (HAS_CE3 != 0) ? !chip_sel_expand_lo_n_i
                                     : 1'b1; // see RULE8

  always @*
  begin
    lane_sel = {!byte_lane3_write_sel_n_i, !byte_lane2_write_sel_n_i,
                !byte_lane1_write_sel_n_i, !byte_lane0_write_sel_n_i};
    // all three enables decide select versus deselect
    chip_active = !chip_sel_primary_n_i     // see RULE7
                  && chip_sel_expand_hi_i  // see RULE6
                  && ce3_active;            // see RULE8
    // processor strobe is void while the first enable is high
    proc_load   = !proc_addr_strobe_n_i
                  && !chip_sel_primary_n_i; // see RULE9
    // controller strobe counts only when the processor one does not
    ctrl_load   = !ctrl_addr_strobe_n_i && !proc_load; // see RULE11
    strobe_load = (proc_load || ctrl_load) && !sleep_sync_q;
    base_d      = base_q;
    sel_d       = selected_q;
    access      = 1'b0;
    if (sleep_sync_q)
    begin
      // sleeping: no access, state and array contents held
      sel_d  = selected_q; // see RULE17
      access = 1'b0;
    end
    else if (strobe_load)
    begin
      sel_d = chip_active;
      if (chip_active)
      begin
        base_d = addr_upper_i; // see RULE1
        access = 1'b1;
      end
    end
    else
      access = selected_q;
    // processor-strobe cycles start as reads; writes follow later
    is_write = 1'b0;
    lane_wr  = `SBS_LANE_NONE;
    if (access && !proc_load)
    begin
      if (!all_bytes_write_n_i)
        lane_wr = `SBS_LANE_ALL; // see RULE4
      else if (!byte_write_qualifier_n_i)
        lane_wr = lane_sel; // see RULE3
      else
        lane_wr = `SBS_LANE_NONE; // see RULE15
      is_write = !all_bytes_write_n_i || !byte_write_qualifier_n_i;
    end
    // drive only on reads that follow a selected cycle
    oe_d = access && !is_write        // see RULE16
           && selected_q              // see RULE13
           && !oe_n_sync_q;           // see RULE12
  end

  always @*
  begin
    wdata = {(LANES*LW){1'b0}};
    for (i = 0; i < LANES; i = i + 1)
      wdata[i*LW +: LW] = {io_parity_lines_i[i], dq_i[i*BYW +: BYW]};
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      selected_q     <= 1'b0;
      base_q         <= {(AW-2){1'b0}};
      dq_oe_o        <= 1'b0;
      selected_o     <= 1'b0;
      sleep_active_o <= 1'b0;
    end
    else
    begin
      selected_q     <= sel_d;
      base_q         <= base_d;
      dq_oe_o        <= oe_d;
      selected_o     <= sel_d;
      sleep_active_o <= sleep_sync_q;
    end
  end

  burst_seq_counter #(
    .BW           (BW)
  ) u_burst (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .load_i       (strobe_load && chip_active), // see RULE10 RULE14
    .load_val_i   ({addr_bit_one_i, addr_bit_zero_i}), // see RULE2
    .advance_i    (!strobe_load && selected_q && !sleep_sync_q
                   && !burst_advance_n_i), // see RULE5
    .interleave_i (ilv_sync_q),
    .offset_d_o   (offset_d),
    .offset_q_o   ()
  );

  sram_word_store #(
    .AW        (AW),
    .LANES     (LANES),
    .LW        (LW)
  ) u_store (
    .sys_clk_i (sys_clk_i),
    .addr_i    ({base_d, offset_d}),
    .lane_wr_i (lane_wr),
    .wdata_i   (wdata),
    .rdata_q   (rdata)
  );

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_split
      assign dq_o[g*BYW +: BYW]   = rdata[g*LW +: BYW];
      assign io_parity_lines_o[g] = rdata[g*LW + BYW];
    end
  endgenerate
endmodule // sync_burst_sram_control_inputs

// file: sync_burst_sram_control_inputs_sva.sv
// Purpose: port checks of the burst sram control decode
// Assumes: no strobe while the sleep input is being synchronised
// Notes:   oe path is two sync edges plus the output flop
`timescale 1ns/1ps
module sram_ctl_checker #(
  parameter HAS_CE3 = 1
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire proc_addr_strobe_n_i,
  input wire ctrl_addr_strobe_n_i,
  input wire byte_write_qualifier_n_i,
  input wire all_bytes_write_n_i,
  input wire chip_sel_primary_n_i,
  input wire chip_sel_expand_hi_i,
  input wire chip_sel_expand_lo_n_i,
  input wire output_enable_n_i,
  input wire dq_oe_o,
  input wire selected_o,
  input wire sleep_active_o
);
  wire en = !chip_sel_primary_n_i && chip_sel_expand_hi_i &&
            (!chip_sel_expand_lo_n_i || HAS_CE3 == 0);
  wire ld = !ctrl_addr_strobe_n_i ||
            (!proc_addr_strobe_n_i && !chip_sel_primary_n_i);
  // proc strobe load is always a read
  wire wr = !ctrl_addr_strobe_n_i && !all_bytes_write_n_i &&
            (proc_addr_strobe_n_i || chip_sel_primary_n_i);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_sel_on_load: assert property (
    ld && en && !sleep_active_o |=> selected_o)
    else $error("no select after strobe");
  a_desel_on_load: assert property (
    ld && !en && !sleep_active_o |=> !selected_o)
    else $error("no deselect after strobe");
  a_proc_ignored: assert property (
    !proc_addr_strobe_n_i && chip_sel_primary_n_i &&
    ctrl_addr_strobe_n_i |=> $stable(selected_o))
    else $error("proc strobe acted with enable high");
  a_desel_float: assert property (
    !selected_o |-> !dq_oe_o)
    else $error("driven while deselected");
  a_first_masked: assert property (
    !selected_o ##1 selected_o |-> !dq_oe_o)
    else $error("driven on first read after deselect");
  a_write_float: assert property (
    wr && en && !sleep_active_o |=> !dq_oe_o)
    else $error("driven during write");
  a_oe_off: assert property (
    output_enable_n_i [*3] |=> !dq_oe_o)
    else $error("driven with oe high");
  a_oe_on: assert property (
    (!output_enable_n_i) [*3] ##0 (selected_o && !ld &&
    all_bytes_write_n_i && byte_write_qualifier_n_i && !sleep_active_o)
    |=> dq_oe_o)
    else $error("not driven on read beat");
  a_sleep_float: assert property (
    sleep_active_o |-> !dq_oe_o)
    else $error("driven while asleep");
endmodule // sram_ctl_checker

// file: bus_master_model.sv
// Purpose: bus master driving the sram control inputs
// Assumes: beat is called at a falling edge
// Notes:   released data lines flip, no pull on them
`timescale 1ns/1ps
module bus_master_model (
  input  wire        sys_clk_i,
  output reg  [11:0] ctl_o,
  output reg  [17:0] addr_o,
  output reg  [35:0] dat_o,
  output reg         oe_n_o,
  output reg         order_o
);
  initial
  begin
    ctl_o = 12'h5ff;
    addr_o = 18'h00000;
    dat_o = 36'h000000000;
    oe_n_o = 1'b0;
    order_o = 1'b0;
  end
  task beat(input [11:0] c, input [17:0] a, input [35:0] d);
  begin
    ctl_o = c;
    addr_o = a;
    if (c[8:3] != 6'h3f)
      dat_o = d;
    else
      dat_o = ~dat_o;
    @(negedge sys_clk_i);
  end
  endtask
endmodule // bus_master_model

// file: test_sync_burst_sram_control_inputs.sv
// Purpose: directed bench of the burst sram control decode
// Assumes: one bus beat per clock, inputs move at falling edge
// Notes:   sleep is raised only while deselected and with no strobe
`timescale 1ns/1ps
module test_sync_burst_sram_control_inputs;
  localparam [11:0] IDLE = 12'h5ff, P = 12'h001, C = 12'h002;
  localparam [11:0] V = 12'h004, L0 = 12'h008, L1 = 12'h010;
  localparam [11:0] Q = 12'h080, G = 12'h100, E1 = 12'h200;
  localparam [11:0] E2 = 12'h400, E3 = 12'h800;
  localparam [17:0] ADR_X = 18'h2a5a4, ADR_Y = 18'h00108;
  localparam [17:0] B = 18'h01230;
  localparam [35:0] W0 = 36'h912345670;
  reg sys_clk_i;
  reg rst_n_i;
  reg sleep_req;
  wire [11:0] ctl;
  wire [17:0] addr;
  wire [35:0] dat;
  wire oe_n, order, dq_oe_o, selected_o, sleep_active_o;
  wire [31:0] dq_o;
  wire [3:0] par_o;
  wire [35:0] rd = {par_o, dq_o};
  integer miscompares = 0;
  integer n_tests = 0;
  integer cyc = 0;
  bus_master_model i_bus (.sys_clk_i(sys_clk_i), .ctl_o(ctl),
    .addr_o(addr), .dat_o(dat), .oe_n_o(oe_n), .order_o(order));
  sync_burst_sram_control_inputs i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .addr_upper_i(addr[17:2]), .addr_bit_one_i(addr[1]),
    .addr_bit_zero_i(addr[0]),
    .proc_addr_strobe_n_i(ctl[0]), .ctrl_addr_strobe_n_i(ctl[1]),
    .burst_advance_n_i(ctl[2]),
    .byte_lane0_write_sel_n_i(ctl[3]), .byte_lane1_write_sel_n_i(ctl[4]),
    .byte_lane2_write_sel_n_i(ctl[5]), .byte_lane3_write_sel_n_i(ctl[6]),
    .byte_write_qualifier_n_i(ctl[7]), .all_bytes_write_n_i(ctl[8]),
    .chip_sel_primary_n_i(ctl[9]), .chip_sel_expand_hi_i(ctl[10]),
    .chip_sel_expand_lo_n_i(ctl[11]), .output_enable_n_i(oe_n),
    .sleep_request_i(sleep_req), .burst_order_interleaved_i(order),
    .dq_i(dat[31:0]), .io_parity_lines_i(dat[35:32]), .dq_o(dq_o),
    .io_parity_lines_o(par_o), .dq_oe_o(dq_oe_o),
    .selected_o(selected_o), .sleep_active_o(sleep_active_o));
  task cmp_word(input [35:0] e, input [35:0] g);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  end
  endtask
  task cmp_bit(input e, input g);
  begin
    cmp_word({35'h0, e}, {35'h0, g});
  end
  endtask
  task end_sim;
  begin
    $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task t_write_read;
  begin
    i_bus.beat(IDLE ^ C ^ G, ADR_X, W0);
    i_bus.beat(IDLE ^ P, ADR_X, 36'h0);
    cmp_word(W0, rd);
    cmp_bit(1'b1, dq_oe_o);
    // lane write: qualifier with select, then select alone
    i_bus.beat(IDLE ^ C ^ G, ADR_Y, 36'h0);
    i_bus.beat(IDLE ^ C ^ Q ^ L0, ADR_Y, 36'hfffffffff);
    i_bus.beat(IDLE ^ C ^ L1, ADR_Y, 36'hfffffffff);
    i_bus.beat(IDLE ^ C, ADR_Y, 36'h0);
    cmp_word(36'h1000000ff, rd);
    $display("t_write_read done");
  end
  endtask
  task t_burst;
    integer m, i;
  begin
    for (i = 0; i < 4; i = i + 1)
      i_bus.beat(IDLE ^ C ^ G, B + i, W0 + i);
    for (m = 0; m < 2; m = m + 1)
    begin
      i_bus.order_o = m[0];
      repeat (3)
        i_bus.beat(IDLE, B, 36'h0);
      for (i = 0; i < 4; i = i + 1)
      begin
        i_bus.beat(i == 0 ? IDLE ^ C : IDLE ^ V, B + 1, 36'h0);
        cmp_word(W0 + (m ? 1 ^ i : (1 + i) % 4), rd);
      end
    end
    $display("t_burst done");
  end
  endtask
  task t_desel;
  begin
    i_bus.beat(IDLE ^ C ^ E2, ADR_X, 36'h0);
    cmp_bit(1'b0, selected_o);
    cmp_bit(1'b0, dq_oe_o);
    i_bus.beat(IDLE ^ C, ADR_X, 36'h0);
    cmp_bit(1'b0, dq_oe_o);
    i_bus.beat(IDLE ^ C ^ E3, ADR_X, 36'h0);
    cmp_bit(1'b0, selected_o);
    i_bus.beat(IDLE ^ P ^ C ^ G, ADR_X, 36'h0);
    cmp_bit(1'b1, selected_o);
    i_bus.beat(IDLE, ADR_X, 36'h0);
    cmp_word(W0, rd);
    // selected here, so an honoured strobe would deselect
    i_bus.beat(IDLE ^ P ^ E1, ADR_X, 36'h0);
    cmp_bit(1'b1, selected_o);
    i_bus.beat(IDLE ^ C ^ E1, ADR_X, 36'h0);
    cmp_bit(1'b0, selected_o);
    i_bus.beat(IDLE ^ C, ADR_X, 36'h0);
    i_bus.oe_n_o = 1'b1;
    repeat (3)
      i_bus.beat(IDLE, ADR_X, 36'h0);
    cmp_bit(1'b0, dq_oe_o);
    i_bus.oe_n_o = 1'b0;
    repeat (3)
      i_bus.beat(IDLE, ADR_X, 36'h0);
    cmp_bit(1'b1, dq_oe_o);
    $display("t_desel done");
  end
  endtask
  task t_sleep;
  begin
    // enter and leave deselected, no strobe while sleep syncs
    i_bus.beat(IDLE ^ C ^ E2, ADR_X, 36'h0);
    sleep_req = 1'b1;
    repeat (3)
      i_bus.beat(IDLE, ADR_X, 36'h0);
    cmp_bit(1'b1, sleep_active_o);
    i_bus.beat(IDLE ^ C ^ G, ADR_X, 36'h0);
    cmp_bit(1'b0, selected_o);
    cmp_bit(1'b0, dq_oe_o);
    sleep_req = 1'b0;
    repeat (3)
      i_bus.beat(IDLE, ADR_X, 36'h0);
    cmp_bit(1'b0, sleep_active_o);
    i_bus.beat(IDLE ^ C, ADR_X, 36'h0);
    cmp_word(W0, rd);
    $display("t_sleep done");
  end
  endtask
  initial
  begin
    sys_clk_i = 1'b0;
    forever
      #12.5 sys_clk_i = ~sys_clk_i;
  end
  // bound well above the fifty beats of the run
  always @(posedge sys_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 500)
    begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  initial
  begin
    rst_n_i = 1'b0;
    sleep_req = 1'b0;
    // count rising edges: the clock's first step at time 0 is a fall
    repeat (3)
      @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (3)
      i_bus.beat(IDLE, ADR_X, 36'h0);
    t_write_read;
    t_burst;
    t_desel;
    t_sleep;
    end_sim;
  end
endmodule // test_sync_burst_sram_control_inputs
bind sync_burst_sram_control_inputs sram_ctl_checker #(.HAS_CE3(HAS_CE3))
  i_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .proc_addr_strobe_n_i(proc_addr_strobe_n_i),
  .ctrl_addr_strobe_n_i(ctrl_addr_strobe_n_i),
  .byte_write_qualifier_n_i(byte_write_qualifier_n_i),
  .all_bytes_write_n_i(all_bytes_write_n_i),
  .chip_sel_primary_n_i(chip_sel_primary_n_i),
  .chip_sel_expand_hi_i(chip_sel_expand_hi_i),
  .chip_sel_expand_lo_n_i(chip_sel_expand_lo_n_i),
  .output_enable_n_i(output_enable_n_i), .dq_oe_o(dq_oe_o),
  .selected_o(selected_o), .sleep_active_o(sleep_active_o));
